// ==== core/csi_sync_framer.sv ====
// How it works
// R1: second zero byte after ones pattern becomes 0x01
// R2: frame rise then first line rise sends frame start
// R3: later line rises in frame send line start
// R4: line fall sends line end code
// R5: line and frame falling together send frame end
// R6: mode low: late frame fall sends frame end
// R7: system picks mode by receiver tolerance
// R8: mode high: count line rises while frame valid
// R9: frame fall stores count as limit, clears counter
// R10: count reaching limit sends frame end instead
// R11: lines past early frame end become blanking
// R12: short frame: line end, frame end later
// R13: enable low over 10 us: shutdown, outputs off
// R14: slow pixel clock: standby, outputs off
// R15: fast pixel clock leaves power-down modes (here standby only; shutdown is left by enable)
// R16: enable high over 10 us: shutdown to standby
// R17: clock activity in standby moves to acquire
// R18: mode low: lock plus one frame rise transmits
// R19: mode high: lock plus two frame rises transmits
// R20: transmit with lock drives serial clock, data
// R21: sync codes are FF0000 followed by kind byte
// R22: sample on falling pixel clock, 8x bit rate
// R23: lsb first, change on falling clock, idle high
// R24: line limit capped at 2046, excess flagged
// R25: activity and lock come from input pins
`timescale 1ns/1ps
`default_nettype none
module csi_sync_framer #(
    parameter int unsigned EN_CYCLES = csi_framer_pkg::ENABLE_HOLD_CYCLES,
    parameter int unsigned MAX_LINE = csi_framer_pkg::MAX_LINES
) (
    input wire logic clk_i,                            // core clock
    input wire logic sys_rst_i,                        // async reset, active high
    input wire logic ser_clk_i,                        // pll clock, two per serial bit
    input wire logic pixel_clock_in_i,                 // camera pixel clock pin
    input wire csi_framer_pkg::cam_s cam_i,            // camera strobes and byte
    input wire csi_framer_pkg::ctl_s ctl_i,            // enable, mode, detector, lock pins
    output var csi_framer_pkg::ser_s ser_o,            // serial clock, data, drive enable
    output var csi_framer_pkg::power_e power_state_o,  // current power mode
    output var logic line_overflow_o                   // too many lines in this frame
);
    import csi_framer_pkg::*;

    localparam int unsigned EN_W = $clog2(EN_CYCLES + 1);

    typedef struct packed {
        cam_s cam1, cam2, cam3, cam_q, prev;
        ctl_s ctl1, ctl2, ctl3, ctl;
        logic pc1, pc2, pc3, pc_lvl;
        power_e pwr;
        logic tx_on;
        logic [EN_W-1:0] en_cnt;
        logic fv_seen;
        logic await_first, in_line, frame_open, frame_done, overflow;
        logic [LINE_W-1:0] line_cnt, line_lim;
        logic [4:0] dly_v;
        logic [4:0][7:0] dly_b;
        logic [2:0] end_wait;
        code_e end_kind;
        code_e start_kind;
        logic fe_pend;
        logic [31:0] code_sh;
        logic [2:0] code_left;
        logic [15:0] hist;
        logic [7:0] hold_byte;
        logic hold_tgl;
    } core_s;

    typedef struct packed {
        logic tx1, tx2, tx3, tx_on;
        logic tg1, tg2, tg3, tg_acc;
        logic nxt_v;
        logic [7:0] nxt_byte;
        logic [7:0] sh;
        logic [2:0] bitc;
        ser_s out;
    } ser_state_s;

    localparam ser_state_s SER_RST = '{out: '{sclk: 1'b0, sdata: 1'b1, drive_n: 1'b1},
                                       default: '0};

    core_s r, n;
    ser_state_s rs, ns;

    logic slot, fv_rise, fv_fall, lv_rise, lv_fall, en_long, shut_req, esc_now;
    cam_s cur;
    code_e kind;
    logic [31:0] word;
    logic [7:0] out_byte;
    logic is_code, is_pix, push;

    always_comb begin
        n = r;
        slot = 1'b0;
        fv_rise = 1'b0;
        fv_fall = 1'b0;
        lv_rise = 1'b0;
        lv_fall = 1'b0;
        esc_now = 1'b0;
        kind = CODE_NONE;
        word = '0;
        out_byte = BYTE_IDLE;
        is_code = 1'b0;
        is_pix = 1'b0;
        push = 1'b0;
        cur = r.cam_q;

        // three-stage pin synchronisers; a change is taken once stages two and three agree
        n.cam1 = cam_i;
        n.cam2 = r.cam1;
        n.cam3 = r.cam2;
        n.cam_q = cam_s'((~(r.cam2 ^ r.cam3) & r.cam3) | ((r.cam2 ^ r.cam3) & r.cam_q));
        n.ctl1 = ctl_i; // R25
        n.ctl2 = r.ctl1;
        n.ctl3 = r.ctl2;
        n.ctl = ctl_s'((~(r.ctl2 ^ r.ctl3) & r.ctl3) | ((r.ctl2 ^ r.ctl3) & r.ctl));
        n.pc1 = pixel_clock_in_i;
        n.pc2 = r.pc1;
        n.pc3 = r.pc2;
        n.pc_lvl = (r.pc2 == r.pc3) ? r.pc3 : r.pc_lvl;
        slot = (r.pc2 == r.pc3) && !r.pc3 && r.pc_lvl; // R22

        // enable pin hold timer
        en_long = (r.en_cnt == EN_W'(EN_CYCLES));
        if (n.ctl.transmit_power_enable != r.ctl.transmit_power_enable) begin
            n.en_cnt = '0;
        end else if (!en_long) begin
            n.en_cnt = r.en_cnt + EN_W'(1);
        end
        shut_req = !r.ctl.transmit_power_enable && en_long && (r.pwr != PWR_SHUTDOWN);

        if (slot) begin
            fv_rise = cur.frame_valid && !r.prev.frame_valid;
            fv_fall = !cur.frame_valid && r.prev.frame_valid;
            lv_rise = cur.line_valid && !r.prev.line_valid;
            lv_fall = !cur.line_valid && r.prev.line_valid;
        end

        // power mode control
        case (r.pwr)
            PWR_SHUTDOWN: begin
                if (r.ctl.transmit_power_enable && en_long) begin
                    n.pwr = PWR_STANDBY; // R16
                end
            end
            PWR_STANDBY: begin
                if (r.ctl.act_high) begin
                    n.pwr = PWR_ACQUIRE; // R15 R17
                end
            end
            PWR_ACQUIRE: begin
                if (r.ctl.act_low) begin
                    n.pwr = PWR_STANDBY; // R14
                end else if (r.ctl.pll_lock && fv_rise) begin
                    if (!r.ctl.mode_high || r.fv_seen) begin
                        n.pwr = PWR_TRANSMIT; // R18 R19
                    end else begin
                        n.fv_seen = 1'b1; // R19
                    end
                end
            end
            PWR_TRANSMIT: begin
                if (r.ctl.act_low) begin
                    n.pwr = PWR_STANDBY; // R14
                end else if (!r.ctl.pll_lock) begin
                    n.pwr = PWR_ACQUIRE;
                end
            end
            default: begin
                n.pwr = PWR_SHUTDOWN;
            end
        endcase
        if (shut_req) begin
            n.pwr = PWR_SHUTDOWN; // R13
        end
        if ((n.pwr != PWR_ACQUIRE) || !r.ctl.pll_lock) begin
            n.fv_seen = 1'b0;
        end
        n.tx_on = (n.pwr == PWR_TRANSMIT); // R20

        if (slot) begin
            n.prev = cur;

            // byte for this pixel slot: running code, due code, delayed pixel, else idle
            if (r.end_wait > 3'h1) begin
                n.end_wait = r.end_wait - 3'h1;
            end
            if (r.code_left != 3'h0) begin
                out_byte = r.code_sh[31:24];
                n.code_sh = {r.code_sh[23:0], 8'h00};
                n.code_left = r.code_left - 3'h1;
                is_code = 1'b1;
            end else if (r.end_wait == 3'h1) begin
                kind = r.end_kind;
                n.end_wait = 3'h0;
            end else if (r.start_kind != CODE_NONE) begin
                kind = r.start_kind;
                n.start_kind = CODE_NONE;
            end else if (r.fe_pend) begin
                kind = CODE_FRAME_END;
                n.fe_pend = 1'b0;
            end
            if (kind != CODE_NONE) begin
                word = code_word(kind); // R21
                out_byte = word[31:24];
                n.code_sh = {word[23:0], 8'h00};
                n.code_left = CODE_TAIL_BYTES;
                is_code = 1'b1;
            end else if (!is_code && r.dly_v[4]) begin
                is_pix = 1'b1;
                esc_now = (r.dly_b[4] == BYTE_ZERO) && escape_hit(r.hist);
                out_byte = esc_now ? BYTE_ESCAPED : r.dly_b[4]; // R1
            end
            n.hist = {out_byte, r.hist[15:8]};
            if (r.tx_on && (is_code || is_pix)) begin
                n.hold_byte = out_byte; // R20
                n.hold_tgl = ~r.hold_tgl;
            end

            // line counter and stored limit
            if (fv_fall) begin
                n.line_lim = r.line_cnt; // R9
                n.line_cnt = '0;
            end else if (r.ctl.mode_high && cur.frame_valid && lv_rise) begin
                if (r.line_cnt == LINE_W'(MAX_LINE)) begin
                    n.overflow = 1'b1; // R24
                end else begin
                    n.line_cnt = r.line_cnt + LINE_W'(1); // R8
                end
            end

            // frame and line starts
            if (fv_rise) begin
                n.await_first = 1'b1;
                n.frame_done = 1'b0;
                n.overflow = 1'b0;
            end
            if (lv_rise && cur.frame_valid && !(r.frame_done && !fv_rise)) begin
                n.in_line = 1'b1;
                n.await_first = 1'b0;
                if (r.await_first || fv_rise) begin
                    n.start_kind = CODE_FRAME_START; // R2
                    n.frame_open = 1'b1;
                end else begin
                    n.start_kind = CODE_LINE_START; // R3
                end
            end

            // line and frame ends, sent after the delayed pixels drain
            if (lv_fall && r.in_line) begin
                n.in_line = 1'b0;
                n.end_wait = END_DELAY;
                if (fv_fall || (r.ctl.mode_high && (r.line_cnt == r.line_lim))) begin
                    n.end_kind = CODE_FRAME_END; // R5 R10
                    n.frame_done = 1'b1; // R11
                    n.frame_open = 1'b0;
                end else begin
                    n.end_kind = CODE_LINE_END; // R4 R12
                end
            end else if (fv_fall) begin
                n.in_line = 1'b0;
                if (r.frame_open && !r.frame_done) begin
                    n.fe_pend = 1'b1; // R6 R12
                    n.frame_open = 1'b0;
                    n.frame_done = 1'b1;
                end
            end

            // pixels are held back five slots so the start code goes first, whole
            push = cur.line_valid && cur.frame_valid && n.in_line; // R11
            n.dly_v = {r.dly_v[3:0], push};
            n.dly_b = {r.dly_b[3:0], cur.data};
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // serial side on the pll clock
    always_comb begin
        ns = rs;
        ns.tx1 = r.tx_on;
        ns.tx2 = rs.tx1;
        ns.tx3 = rs.tx2;
        ns.tx_on = (rs.tx2 == rs.tx3) ? rs.tx3 : rs.tx_on;
        ns.tg1 = r.hold_tgl;
        ns.tg2 = rs.tg1;
        ns.tg3 = rs.tg2;
        ns.out.sclk = ~rs.out.sclk; // R22
        ns.out.drive_n = ~rs.tx_on; // R13 R14 R20
        if (rs.out.sclk) begin
            if (rs.bitc != 3'h0) begin
                ns.out.sdata = rs.sh[0]; // R23
                ns.sh = {1'b1, rs.sh[7:1]};
                ns.bitc = rs.bitc - 3'h1;
            end else if (rs.nxt_v) begin
                ns.out.sdata = rs.nxt_byte[0];
                ns.sh = {1'b1, rs.nxt_byte[7:1]};
                ns.bitc = 3'h7;
                ns.nxt_v = 1'b0;
            end else begin
                ns.out.sdata = 1'b1; // R23
            end
        end
        if ((rs.tg2 == rs.tg3) && (rs.tg3 != rs.tg_acc)) begin
            ns.tg_acc = rs.tg3;
            ns.nxt_byte = r.hold_byte;
            ns.nxt_v = 1'b1;
        end
        if (!rs.tx_on) begin
            ns.out.sdata = 1'b1;
            ns.bitc = 3'h0;
            ns.nxt_v = 1'b0;
        end
    end

    always_ff @(posedge ser_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rs <= SER_RST;
        end else begin
            rs <= ns;
        end
    end

    assign ser_o = rs.out;
    assign power_state_o = r.pwr;
    assign line_overflow_o = r.overflow;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_frame_edge;
        slot && fv_rise;
    endsequence

    sequence s_locked_acquire;
        (r.pwr == PWR_ACQUIRE) && r.ctl.pll_lock && !r.ctl.act_low && !shut_req;
    endsequence

    a_escape_byte: assert property (esc_now && r.tx_on |=> n.hold_byte == BYTE_ESCAPED) // R1
        else $error("escaped zero byte not sent as 0x01");
    a_frame_start: assert property (slot && fv_rise && lv_rise |=> r.start_kind == CODE_FRAME_START
        && r.frame_open) // R2
        else $error("frame start code not queued");
    a_joint_end: assert property (slot && lv_fall && fv_fall && r.in_line |=>
        r.end_kind == CODE_FRAME_END && r.end_wait == END_DELAY) // R5
        else $error("joint fall did not queue frame end");
    a_count_step: assert property (slot && r.ctl.mode_high && cur.frame_valid && lv_rise && !fv_fall
        && r.line_cnt != LINE_W'(MAX_LINE) |=> r.line_cnt == $past(r.line_cnt) + LINE_W'(1)) // R8
        else $error("line counter did not advance");
    a_limit_store: assert property (slot && fv_fall |=> r.line_lim == $past(r.line_cnt)
        && r.line_cnt == '0) // R9
        else $error("line limit not captured at frame end");
    a_early_end: assert property (slot && lv_fall && r.in_line && !fv_fall && r.ctl.mode_high
        && r.line_cnt == r.line_lim |=> r.end_kind == CODE_FRAME_END ##1 !r.in_line) // R10
        else $error("frame end not sent at stored limit");
    a_shutdown_entry: assert property (shut_req |=> r.pwr == PWR_SHUTDOWN ##1
        r.pwr == PWR_SHUTDOWN || r.ctl.transmit_power_enable) // R13
        else $error("enable low did not shut down");
    a_standby_drop: assert property ((r.pwr inside {PWR_ACQUIRE, PWR_TRANSMIT}) && r.ctl.act_low
        && !shut_req |=> r.pwr == PWR_STANDBY ##[1:4] !r.tx_on) // R14
        else $error("slow clock did not force standby");
    a_standby_entry: assert property ((r.pwr == PWR_SHUTDOWN) && r.ctl.transmit_power_enable
        && en_long |=> r.pwr == PWR_STANDBY) // R16
        else $error("enable high did not reach standby");
    a_acquire_entry: assert property ((r.pwr == PWR_STANDBY) && r.ctl.act_high && !shut_req
        |=> r.pwr == PWR_ACQUIRE) // R17
        else $error("clock activity did not start acquire");
    a_one_frame_go: assert property (s_locked_acquire ##0 s_frame_edge ##0 !r.ctl.mode_high
        |=> r.pwr == PWR_TRANSMIT ##1 r.tx_on) // R18
        else $error("mode low did not transmit after one frame edge");
    a_two_frame_go: assert property (s_locked_acquire ##0 s_frame_edge ##0 r.ctl.mode_high
        ##0 !r.fv_seen |=> r.pwr == PWR_ACQUIRE && r.fv_seen) // R19
        else $error("mode high left acquire on first frame edge");
    a_idle_high: assert property (@(posedge ser_clk_i) disable iff (sys_rst_i)
        rs.out.sclk && rs.bitc == 3'h0 && !rs.nxt_v |=> rs.out.sdata && !rs.out.sclk) // R23
        else $error("serial data not high while idle");

endmodule : csi_sync_framer
`default_nettype wire

// ==== inc/csi_framer_pkg.sv ====
package csi_framer_pkg;

    // timing of the enable pin hold before a power change
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned ENABLE_HOLD_NS = 10000;
    localparam int unsigned ENABLE_HOLD_CYCLES = (ENABLE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // line counter limits
    localparam int unsigned MAX_LINES = 2046;
    localparam int unsigned LINE_W = 11;

    // slots between a line start and its first pixel on the wire; the start code
    // leaves one slot after the line rise, so four code bytes fit in front
    localparam logic [2:0] END_DELAY = 3'h5;
    localparam logic [2:0] CODE_TAIL_BYTES = 3'h3;

    // sync code layout: fixed head, kind in the last byte
    localparam logic [23:0] CODE_HEAD = 24'hFF0000;
    localparam logic [7:0] TAIL_LINE_START = 8'h00;
    localparam logic [7:0] TAIL_LINE_END = 8'h01;
    localparam logic [7:0] TAIL_FRAME_START = 8'h02;
    localparam logic [7:0] TAIL_FRAME_END = 8'h03;

    localparam logic [7:0] BYTE_IDLE = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ESCAPED = 8'h01;

    typedef enum logic [1:0] {
        PWR_SHUTDOWN = 2'h0,
        PWR_STANDBY = 2'h1,
        PWR_ACQUIRE = 2'h3,
        PWR_TRANSMIT = 2'h2
    } power_e;

    typedef enum logic [2:0] {
        CODE_NONE = 3'h0,
        CODE_LINE_START = 3'h1,
        CODE_LINE_END = 3'h2,
        CODE_FRAME_START = 3'h3,
        CODE_FRAME_END = 3'h4
    } code_e;

    typedef struct packed {
        logic frame_valid;
        logic line_valid;
        logic [7:0] data;
    } cam_s;

    typedef struct packed {
        logic transmit_power_enable;
        logic mode_high;
        logic act_high;
        logic act_low;
        logic pll_lock;
    } ctl_s;

    typedef struct packed {
        logic sclk;
        logic sdata;
        logic drive_n;
    } ser_s;

    function automatic logic [31:0] code_word(input code_e kind);
        logic [7:0] tail;
        case (kind)
            CODE_LINE_END: tail = TAIL_LINE_END;
            CODE_FRAME_START: tail = TAIL_FRAME_START;
            CODE_FRAME_END: tail = TAIL_FRAME_END;
            default: tail = TAIL_LINE_START;
        endcase
        return {CODE_HEAD, tail};
    endfunction : code_word

    // w = {newest byte, older byte}; true when a zero byte next would finish 8 ones + 9 to 16 zeros
    function automatic logic escape_hit(input logic [15:0] w);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 8; k++) begin
            if ((w[k +: 8] == 8'hFF) && ((w >> (k + 8)) == 16'h0000)) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : escape_hit

endpackage : csi_framer_pkg

// ==== tb/csi_partner_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module csi_partner_model (
    input wire logic clk_i,                  // core clock
    input wire csi_framer_pkg::ser_s ser_i,  // serial clock, data, drive enable
    output var logic pclk_o,                 // camera pixel clock
    output var csi_framer_pkg::cam_s cam_o   // camera strobes and byte
);
    import csi_framer_pkg::*;
    localparam logic [63:0] ESC_LINE = 64'h11FF0000FE010000;
    logic [3:0] pcnt = 4'h0;
    logic [31:0] sh = 32'h0;
    logic [31:0] hist = 32'h0;
    logic [4:0] bitc = 5'h0;
    logic locked = 1'b0;
    logic inl = 1'b0;
    logic [7:0] codes[$];
    logic [7:0] pix_q[$];
    initial pclk_o = 1'b0;
    initial cam_o = '0;
    // slot of 15 core cycles is 25 serial bits, so every byte keeps one phase
    always @(posedge clk_i) begin
        pcnt <= (pcnt == 4'hE) ? 4'h0 : pcnt + 4'h1;
        pclk_o <= (pcnt == 4'hE) || (pcnt < 4'h6);
    end
    task automatic slot(input logic fv, input logic lv, input logic [7:0] d);
        @(posedge clk_i iff (pcnt == 4'hE));
        cam_o <= '{frame_valid: fv, line_valid: lv, data: d};
    endtask : slot
    task automatic clear();
        codes.delete();
        pix_q.delete();
        inl = 1'b0;
    endtask : clear
    task automatic send_frame(input int nl, input logic late);
        repeat (8) slot(1'b0, 1'b0, 8'h00);
        if (late) repeat (8) slot(1'b1, 1'b0, 8'h00);
        for (int l = 0; l < nl; l++) begin
            for (int p = 0; p < 8; p++) begin
                slot(1'b1, 1'b1, (l == 0) ? ESC_LINE[63 - 8 * p -: 8] : 8'h20 + 8'(8 * l + p));
            end
            repeat (8) slot(late || (l < nl - 1), 1'b0, 8'h00);
        end
        repeat (8) slot(1'b0, 1'b0, 8'h00);
    endtask : send_frame
    // receiver: bits taken on the rising serial clock, lsb first
    always @(posedge ser_i.sclk) begin
        if (!ser_i.drive_n) begin
            sh = {ser_i.sdata, sh[31:1]};
            bitc = bitc + 5'h1;
            // a run of exactly eight zeros can only be a zero byte: byte phase found
            if (sh[31:22] == 10'h201) begin
                if (!locked) hist = 32'h0000FF00;
                locked = 1'b1;
                bitc = 5'h1;
            end else if (locked && bitc == 5'h19) begin
                bitc = 5'h0;
                hist = {hist[23:0], sh[31:24]};
                if (hist[31:8] == 24'hFF0000 && hist[7:0] < 8'h04) begin
                    codes.push_back(hist[7:0]);
                    if (inl) repeat (3) void'(pix_q.pop_back());
                    inl = ~hist[0];
                end else if (inl) begin
                    pix_q.push_back(hist[7:0]);
                end
            end
        end else begin
            // outputs off: byte phase is lost, find it again on the next start code
            locked = 1'b0;
        end
    end
endmodule : csi_partner_model
`default_nettype wire

// ==== tb/camera_csi1_sync_framer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module camera_csi1_sync_framer_bench;
    import csi_framer_pkg::*;
    localparam int unsigned EN = 8;
    logic clk_i = 1'b0;
    logic ser_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    ctl_s ctl = '0;
    cam_s cam;
    logic pclk;
    ser_s ser;
    power_e pwr;
    logic ovf;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    initial forever #20 clk_i = ~clk_i;
    initial begin
        #3.7;
        forever #6 ser_clk_i = ~ser_clk_i;
    end
    csi_sync_framer #(.EN_CYCLES(EN), .MAX_LINE(6)) csi_sync_framer_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ser_clk_i(ser_clk_i),
        .pixel_clock_in_i(pclk), .cam_i(cam), .ctl_i(ctl), .ser_o(ser),
        .power_state_o(pwr), .line_overflow_o(ovf));
    csi_partner_model partner_i (.clk_i(clk_i), .ser_i(ser), .pclk_o(pclk), .cam_o(cam));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_pwr(input power_e s, input int lim);
        for (int i = 0; i < lim && pwr !== s; i++) @(posedge clk_i);
        #1;
        chk(pwr, s);
    endtask : wait_pwr
    task automatic run_frame(input int nl, input logic late, input logic [63:0] exp,
                             input int nc, input int np);
        logic [63:0] esc;
        esc = 64'h11FF0001FE010100;
        partner_i.clear();
        partner_i.send_frame(nl, late);
        chk(partner_i.codes.size(), nc);
        for (int i = 0; i < nc && i < partner_i.codes.size(); i++) begin
            chk(partner_i.codes[i], exp[8 * (nc - 1 - i) +: 8]);
        end
        chk(partner_i.pix_q.size(), np);
        for (int i = 0; i < np && i < partner_i.pix_q.size(); i++) begin
            chk(partner_i.pix_q[i], (i < 8) ? esc[63 - 8 * i -: 8] : 8'h20 + 8'(i));
        end
    endtask : run_frame
    task automatic t_power_up();
        chk(pwr, PWR_SHUTDOWN);
        chk(ser.drive_n, 1'b1);
        @(posedge clk_i);
        ctl.transmit_power_enable <= 1'b1;
        repeat (EN - 2) @(posedge clk_i);
        #1;
        chk(pwr, PWR_SHUTDOWN);
        wait_pwr(PWR_STANDBY, 12);
        chk(ser.drive_n, 1'b1);
        @(posedge clk_i);
        ctl.act_high <= 1'b1;
        wait_pwr(PWR_ACQUIRE, 8);
        @(posedge clk_i);
        ctl.pll_lock <= 1'b1;
        repeat (20) @(posedge clk_i);
        #1;
        chk(pwr, PWR_ACQUIRE);
        chk(ser.drive_n, 1'b1);
        run_frame(2, 1'b0, 64'h02010003, 4, 16);
        chk(pwr, PWR_TRANSMIT);
        chk(ser.drive_n, 1'b0);
        $display("power up test done");
    endtask : t_power_up
    task automatic t_late_end();
        run_frame(2, 1'b1, 64'h0201000103, 5, 16);
        $display("late frame end test done");
    endtask : t_late_end
    task automatic t_line_count();
        @(posedge clk_i);
        ctl.pll_lock <= 1'b0;
        wait_pwr(PWR_ACQUIRE, 8);
        @(posedge clk_i);
        ctl.pll_lock <= 1'b1;
        ctl.mode_high <= 1'b1;
        partner_i.send_frame(3, 1'b0);
        chk(pwr, PWR_ACQUIRE);
        run_frame(3, 1'b1, 64'h020100010003, 6, 24);
        chk(pwr, PWR_TRANSMIT);
        run_frame(4, 1'b0, 64'h020100010003, 6, 24);
        run_frame(4, 1'b0, 64'h0201000100010003, 8, 32);
        run_frame(2, 1'b1, 64'h0201000103, 5, 16);
        run_frame(4, 1'b1, 64'h02010003, 4, 16);
        partner_i.send_frame(7, 1'b0);
        chk(ovf, 1'b1);
        $display("line count test done");
    endtask : t_line_count
    task automatic t_power_down();
        @(posedge clk_i);
        ctl.act_high <= 1'b0;
        ctl.act_low <= 1'b1;
        wait_pwr(PWR_STANDBY, 8);
        repeat (2) @(posedge clk_i);
        chk(ser.drive_n, 1'b1);
        @(posedge clk_i);
        ctl.transmit_power_enable <= 1'b0;
        repeat (EN - 2) @(posedge clk_i);
        #1;
        chk(pwr, PWR_STANDBY);
        wait_pwr(PWR_SHUTDOWN, 12);
        chk(ser.drive_n, 1'b1);
        $display("power down test done");
    endtask : t_power_down
    // hang guard, well above the expected run of some 10000 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        t_power_up();
        t_late_end();
        t_line_count();
        t_power_down();
        complete_run();
    end
endmodule : camera_csi1_sync_framer_bench
`default_nettype wire
